// ===== logic/event_capture.sv
// Qualifies engine event pulses into one registered vector of flag set requests.
`timescale 1ns/1ps
module event_capture
  import i2c_event_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire evt_in_t evt,
  input wire cfg_in_t cfg,
  output logic [31:0] ev_set
);
  capture_state_t st_r;
  capture_state_t st_nxt;

  function automatic logic [31:0] bit_if(input logic cond, input int idx);
    bit_if = cond ? (32'h00000001 << idx) : 32'h00000000;
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.ev = 32'h00000000;
    // RULE7 strap after reset.
    if (!st_r.rst_seen) begin
      st_nxt.rst_seen = 1'b1;
      st_nxt.ev = bit_if(cfg.boot_load_disabled, `BIT_BOOT_OK);
    end
    // A software load in the same cycle as an external read keeps the mailbox loaded.
    if (evt.out_mbox_ext_read) begin
      st_nxt.out_mbox_loaded = 1'b0;
    end
    if (evt.out_mbox_sw_write) begin
      st_nxt.out_mbox_loaded = 1'b1;
    end
    // RULE4 loaded mailbox read.
    st_nxt.ev |= bit_if(evt.out_mbox_ext_read && st_r.out_mbox_loaded, `BIT_OUT_MBOX);
    // RULE5 mailbox written.
    st_nxt.ev |= bit_if(evt.in_mbox_ext_write, `BIT_IN_MBOX);
    // RULE6 boot failure.
    st_nxt.ev |= bit_if(evt.boot_fail, `BIT_BOOT_FAIL);
    // RULE7 boot success.
    st_nxt.ev |= bit_if(evt.boot_ok, `BIT_BOOT_OK);
    // RULE8 slave abort.
    st_nxt.ev |= bit_if(evt.slave_abort, `BIT_SLV_ERR);
    // RULE9 gated slave write.
    st_nxt.ev |= bit_if(evt.slave_wr_access && cfg.slave_write_enable, `BIT_SLV_WR);
    // RULE10 gated slave read.
    st_nxt.ev |= bit_if(evt.slave_rd_access && cfg.slave_read_enable, `BIT_SLV_RD);
    // RULE11 slave success.
    st_nxt.ev |= bit_if(evt.slave_ok, `BIT_SLV_OK);
    // RULE12 master diagnostic.
    st_nxt.ev |= bit_if(evt.master_diag, `BIT_MST_DIAG);
    // RULE13 RULE18 arbitration loss.
    st_nxt.ev |= bit_if(evt.master_arb_lost || evt.boot_arb_lost, `BIT_MST_ARB);
    // RULE14 RULE18 master timeout.
    st_nxt.ev |= bit_if(evt.master_timeout || evt.boot_timeout, `BIT_MST_TMO);
    // RULE15 RULE18 master NACK.
    st_nxt.ev |= bit_if(evt.master_nack || evt.boot_nack, `BIT_MST_NACK);
    // RULE16 arbitration timeout.
    st_nxt.ev |= bit_if(evt.master_arb_timeout, `BIT_MST_ATMO);
    // RULE17 master success.
    st_nxt.ev |= bit_if(evt.master_ok, `BIT_MST_OK);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ev_set = st_r.ev;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_mbox_gate;
    evt.out_mbox_ext_read && !st_r.out_mbox_loaded |=> !ev_set[`BIT_OUT_MBOX];
  endproperty
  a_mbox_gate: assert property (p_mbox_gate) // RULE4
    else $error("Mailbox empty raised without a prior software load.");
  property p_mbox_full;
    evt.in_mbox_ext_write |=> ev_set[`BIT_IN_MBOX];
  endproperty
  a_mbox_full: assert property (p_mbox_full) // RULE5
    else $error("Mailbox full event lost.");
  property p_boot_strap;
    !st_r.rst_seen && cfg.boot_load_disabled |=> ev_set[`BIT_BOOT_OK] ##1 st_r.rst_seen;
  endproperty
  a_boot_strap: assert property (p_boot_strap) // RULE7
    else $error("Boot load done missing with boot load disabled.");
  property p_wr_block;
    !cfg.slave_write_enable |=> !ev_set[`BIT_SLV_WR];
  endproperty
  a_wr_block: assert property (p_wr_block) // RULE9
    else $error("Slave write flagged while slave writes disabled.");
  property p_rd_block;
    !cfg.slave_read_enable |=> !ev_set[`BIT_SLV_RD];
  endproperty
  a_rd_block: assert property (p_rd_block) // RULE10
    else $error("Slave read flagged while slave reads disabled.");
  property p_boot_nack;
    evt.boot_nack |=> ev_set[`BIT_MST_NACK];
  endproperty
  a_boot_nack: assert property (p_boot_nack) // RULE18
    else $error("Boot load NACK cause not flagged.");
endmodule

// ===== logic/i2c_event_status.sv
// Event status, enable and set registers of the serial unit with its interrupt request.
`timescale 1ns/1ps
module i2c_event_status
  import i2c_event_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic unit_soft_reset,
  input wire reg_req_t req,
  output logic [31:0] reg_rdata,
  output logic reg_ack,
  input wire evt_in_t evt,
  input wire cfg_in_t cfg,
  input wire logic [31:0] source_active_mask,
  output logic irq
);
  status_state_t st_r;
  status_state_t st_nxt;
  logic [31:0] ev_set;
  logic wr_status;
  logic wr_enable;
  logic wr_set;
  logic [31:0] clr_vec;
  logic [31:0] force_vec;

  function automatic logic hit(input reg_req_t r, input logic [`ADDR_W-1:0] ofs);
    hit = r.sel && (r.addr == ofs);
  endfunction

  event_capture u_capture (
    .clock(clock),
    .sys_rst(sys_rst),
    .evt(evt),
    .cfg(cfg),
    .ev_set(ev_set)
  );

  // RULE1 request drive.
  irq_combine #(
    .WIDTH(32)
  ) u_irq (
    .flags(st_r.flags),
    .enables(st_r.enable),
    .irq(irq)
  );

  assign wr_status = hit(req, `STATUS_OFS) && req.wr;
  assign wr_enable = hit(req, `ENABLE_OFS) && req.wr;
  assign wr_set = hit(req, `SET_OFS) && req.wr;
  // RULE19 write one clears.
  assign clr_vec = wr_status ? req.wdata : 32'h00000000;
  // RULE22 set through sources.
  assign force_vec = wr_set ? (req.wdata & source_active_mask) : 32'h00000000;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.rdata = 32'h00000000;
    // RULE2 RULE19 set beats clear.
    st_nxt.flags = ((st_r.flags & ~clr_vec) | ev_set | force_vec) & `FLAG_MASK;
    // RULE3 soft reset clear.
    if (unit_soft_reset) begin
      st_nxt.flags = `STATUS_RST;
    end
    // RULE21 enable write.
    if (wr_enable) begin
      st_nxt.enable = req.wdata & `FLAG_MASK;
    end
    if (req.sel) begin
      st_nxt.ack = 1'b1;
      if (!req.wr) begin
        // RULE20 RULE23 readback.
        case (req.addr)
          `STATUS_OFS: st_nxt.rdata = st_r.flags;
          `ENABLE_OFS: st_nxt.rdata = st_r.enable;
          `SET_OFS: st_nxt.rdata = st_r.flags;
          default: st_nxt.rdata = 32'h00000000;
        endcase
      end
    end
  end

  // RULE20 reset to zero.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_r.flags <= `STATUS_RST;
      st_r.enable <= `ENABLE_RST;
      st_r.rdata <= 32'h00000000;
      st_r.ack <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reg_ack = st_r.ack;

  // Checks below tie flag and request behaviour to bus traffic and engine events.
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_quiet_cycle;
    !unit_soft_reset && (ev_set == 32'h00000000) && !wr_set && !wr_status;
  endsequence

  sequence s_soft_release;
    unit_soft_reset ##1 s_quiet_cycle;
  endsequence

  sequence s_status_read;
    req.sel && !req.wr && (req.addr == `STATUS_OFS);
  endsequence

  property p_irq_raise;
    !unit_soft_reset && !wr_enable && ((ev_set & st_r.enable) != 32'h00000000) |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) // RULE1
    else $error("Enabled event did not raise the request.");

  property p_irq_follows;
    !unit_soft_reset && !wr_enable && !wr_status && irq |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // RULE1
    else $error("Request dropped without clear, soft reset or enable change.");

  property p_flag_unmasked;
    !unit_soft_reset && (ev_set != 32'h00000000)
      |=> ((st_r.flags & $past(ev_set)) == $past(ev_set));
  endproperty
  a_flag_unmasked: assert property (p_flag_unmasked) // RULE2
    else $error("Event did not set its flag.");

  property p_disabled_silent;
    (st_r.enable == 32'h00000000) && !wr_enable |=> !irq;
  endproperty
  a_disabled_silent: assert property (p_disabled_silent) // RULE2
    else $error("Request raised with every enable clear.");

  property p_soft_clear;
    unit_soft_reset |=> (st_r.flags == 32'h00000000) && !irq;
  endproperty
  a_soft_clear: assert property (p_soft_clear) // RULE3
    else $error("Soft reset left a flag or request standing.");

  property p_soft_quiet;
    s_soft_release |=> !irq;
  endproperty
  a_soft_quiet: assert property (p_soft_quiet) // RULE3
    else $error("Request rose after soft reset without a new event.");

  property p_w1c;
    wr_status && !unit_soft_reset && (ev_set == 32'h00000000)
      |=> (st_r.flags == ($past(st_r.flags) & ~$past(req.wdata)));
  endproperty
  a_w1c: assert property (p_w1c) // RULE19
    else $error("Write one to clear did not clear exactly the written ones.");

  property p_set_wins;
    wr_status && !unit_soft_reset
      |=> ((st_r.flags & $past(ev_set)) == $past(ev_set));
  endproperty
  a_set_wins: assert property (p_set_wins) // RULE19
    else $error("Event lost under a simultaneous clear.");

  property p_reset_zero;
    disable iff (1'b0)
    sys_rst |=> (st_r.flags == 32'h00000000) && (st_r.enable == 32'h00000000) && !irq;
  endproperty
  a_reset_zero: assert property (p_reset_zero) // RULE20
    else $error("Registers not zero after reset.");

  property p_status_read;
    s_status_read |=> reg_ack && (reg_rdata == $past(st_r.flags));
  endproperty
  a_status_read: assert property (p_status_read) // RULE20
    else $error("Status read returned wrong data.");

  property p_enable_write;
    wr_enable |=> (st_r.enable == ($past(req.wdata) & `FLAG_MASK));
  endproperty
  a_enable_write: assert property (p_enable_write) // RULE21
    else $error("Enable write not stored.");

  property p_enable_hold;
    !wr_enable |=> $stable(st_r.enable);
  endproperty
  a_enable_hold: assert property (p_enable_hold) // RULE21
    else $error("Enable changed without a write.");

  property p_set_force;
    wr_set && !unit_soft_reset && (ev_set == 32'h00000000)
      |=> (st_r.flags == ($past(st_r.flags)
          | ($past(req.wdata) & $past(source_active_mask) & `FLAG_MASK)));
  endproperty
  a_set_force: assert property (p_set_force) // RULE22
    else $error("Set write forced the wrong flags.");

  property p_reserved_zero;
    reg_ack |-> ((reg_rdata & ~`FLAG_MASK) == 32'h00000000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) // RULE23
    else $error("Reserved bits read as one.");

  property p_flags_masked;
    s_quiet_cycle ##1 1'b1 |-> ((st_r.flags & ~`FLAG_MASK) == 32'h00000000);
  endproperty
  a_flags_masked: assert property (p_flags_masked) // RULE23
    else $error("Reserved flag position set.");
endmodule

// ===== logic/irq_combine.sv
// Reduction of enabled event flags onto one interrupt request.
`timescale 1ns/1ps
module irq_combine #(
  parameter int WIDTH = 32
) (
  input wire logic [WIDTH-1:0] flags,
  input wire logic [WIDTH-1:0] enables,
  output logic irq
);
  // RULE23 masked OR.
  assign irq = |(flags & enables);
endmodule

// ===== shared/i2c_event_map.svh
// Register offsets, field positions and reset values of the serial unit event status block.
// Operation
// RULE1: Interrupt request is raised whenever a flag and its enable are both set.
// RULE2: Flags still set when their enable is clear; only the request is held off.
// RULE3: Soft reset clears all flags; no request until a new event follows release.
// RULE4: Outgoing mailbox empty flag sets on external read, only if software loaded it.
// RULE5: Incoming mailbox full flag sets when an external master writes the mailbox.
// RULE6: Boot load failed flag sets when the boot load sequence fails.
// RULE7: Boot load done flag sets on success, or when boot load was disabled at reset.
// RULE8: Slave access error flag sets when an addressed slave transaction aborts.
// RULE9: Slave register write flag sets on a triggered write, never with writes disabled.
// RULE10: Slave register read flag sets on a triggered read, never with reads disabled.
// RULE11: Slave access done flag sets when an addressed slave transaction completes cleanly.
// RULE12: Master diagnostic flag sets when the master engine reports a diagnostic event.
// RULE13: Master arbitration lost flag sets on arbitration loss after the address phase.
// RULE14: Master timeout flag sets on clock low, byte or transaction timeout abort.
// RULE15: Master NACK flag sets on a NACK to address, peripheral address or data.
// RULE16: Master arbitration timeout flag sets when the bus arbitration timeout expires.
// RULE17: Master done flag sets when a master transaction completes without error.
// RULE18: A failed boot load may also set the collision, timeout and NACK flags.
// RULE19: Writing one clears a flag, zero leaves it; software reads before clearing.
// RULE20: Status is reachable only from the register bus and resets to zero.
// RULE21: Enable register holds one read-write enable per flag, reset to zero.
// RULE22: Set register forces flags on, but only where underlying events are enabled.
// RULE23: Request is the OR of flag AND enable; reserved bits read zero.
`ifndef I2C_EVENT_MAP_SVH
`define I2C_EVENT_MAP_SVH
`define ADDR_W 20
`define STATUS_OFS 20'h1D11C
`define ENABLE_OFS 20'h1D120
`define SET_OFS 20'h1D124
`define STATUS_RST 32'h00000000
`define ENABLE_RST 32'h00000000
`define FLAG_MASK 32'hF9F0C0C0
`define BIT_OUT_MBOX 6
`define BIT_IN_MBOX 7
`define BIT_BOOT_FAIL 14
`define BIT_BOOT_OK 15
`define BIT_SLV_ERR 20
`define BIT_SLV_WR 21
`define BIT_SLV_RD 22
`define BIT_SLV_OK 23
`define BIT_MST_DIAG 24
`define BIT_MST_ARB 27
`define BIT_MST_TMO 28
`define BIT_MST_NACK 29
`define BIT_MST_ATMO 30
`define BIT_MST_OK 31
`endif

// ===== shared/i2c_event_pkg.sv
// Types shared by the serial unit event status block.
`include "i2c_event_map.svh"
package i2c_event_pkg;
  typedef struct packed {
    logic sel;
    logic wr;
    logic [`ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic out_mbox_sw_write;
    logic out_mbox_ext_read;
    logic in_mbox_ext_write;
    logic boot_fail;
    logic boot_ok;
    logic slave_abort;
    logic slave_wr_access;
    logic slave_rd_access;
    logic slave_ok;
    logic master_diag;
    logic master_arb_lost;
    logic master_timeout;
    logic master_nack;
    logic master_arb_timeout;
    logic master_ok;
    logic boot_arb_lost;
    logic boot_timeout;
    logic boot_nack;
  } evt_in_t;
  typedef struct packed {
    logic slave_write_enable;
    logic slave_read_enable;
    logic boot_load_disabled;
  } cfg_in_t;
  typedef struct packed {
    logic rst_seen;
    logic out_mbox_loaded;
    logic [31:0] ev;
  } capture_state_t;
  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] enable;
    logic [31:0] rdata;
    logic ack;
  } status_state_t;
endpackage

// ===== tb/irq_sink.sv
// Interrupt controller stand-in that latches a request until it is acknowledged.
`timescale 1ns/1ps
module irq_sink (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic irq,
  input wire logic ack_clear,
  output logic pending
);
  // The request is a level, so a latch shows whether it was ever raised.
  always_ff @(posedge clock) begin
    if (sys_rst || ack_clear) begin
      pending <= 1'b0;
    end else if (irq) begin
      pending <= 1'b1;
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the serial unit event status block.
`timescale 1ns/1ps
`include "i2c_event_map.svh"
module tb;
  import i2c_event_pkg::*;
  logic clock;
  logic sys_rst;
  logic unit_soft_reset;
  reg_req_t req;
  logic [31:0] reg_rdata;
  logic reg_ack;
  evt_in_t evt;
  cfg_in_t cfg;
  logic [31:0] source_active_mask;
  logic irq;
  logic ack_clear;
  logic pending;
  logic [31:0] exp_v;
  int n_fail;
  int samples_checked;
  int fmap[16] = '{29, 28, 27, 31, 30, 29, 28, 27, 24, 23, 22, 21, 20, 15, 14, 7};

  i2c_event_status i2c_event_status_inst (
    .clock(clock), .sys_rst(sys_rst), .unit_soft_reset(unit_soft_reset), .req(req),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .evt(evt), .cfg(cfg),
    .source_active_mask(source_active_mask), .irq(irq)
  );
  irq_sink irq_sink_inst (
    .clock(clock), .sys_rst(sys_rst), .irq(irq), .ack_clear(ack_clear), .pending(pending)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask

  // One access; the answer stands in the cycle after the taking edge.
  task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(negedge clock);
    req <= '{1'b1, w, a, d};
    @(negedge clock);
    req.sel <= 1'b0;
    r = reg_rdata;
    chk({31'h0, reg_ack}, 32'h1);
  endtask

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [19:0] a, input logic [31:0] e);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic pulse(input logic [17:0] v);
    @(negedge clock);
    evt <= evt_in_t'(v);
    @(negedge clock);
    evt <= '0;
    repeat (2) @(negedge clock);
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    $display("FAIL %0t run did not finish", $time);
    stop_test();
  end

  initial begin
    sys_rst = 1'b1;
    unit_soft_reset = 1'b0;
    req = '0;
    evt = '0;
    cfg = '{1'b1, 1'b1, 1'b1};
    source_active_mask = 32'hFFFFFFFF;
    ack_clear = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    repeat (12) @(posedge clock);
    @(negedge clock);
    sys_rst <= 1'b0;
    cfg.boot_load_disabled <= 1'b1;
    rd_chk(`STATUS_OFS, `STATUS_RST);
    rd_chk(`ENABLE_OFS, `ENABLE_RST);
    repeat (3) @(negedge clock);
    rd_chk(`STATUS_OFS, 32'h00008000);
    wr(`STATUS_OFS, 32'h00008000);
    rd_chk(`STATUS_OFS, 32'h0);
    rd_chk(20'h1D128, 32'h0);
    // With enables clear every event but the two outgoing mailbox ones still lands in its flag.
    for (int e = 0; e < 16; e++) begin
      pulse(18'(1) << e);
      rd_chk(`STATUS_OFS, 32'h1 << fmap[e]);
      chk({31'h0, irq}, 32'h0);
      wr(`STATUS_OFS, 32'hFFFFFFFF);
    end
    // An external read of a never loaded mailbox must stay silent.
    pulse(18'h10000);
    rd_chk(`STATUS_OFS, 32'h0);
    pulse(18'h20000);
    pulse(18'h10000);
    rd_chk(`STATUS_OFS, 32'h40);
    wr(`STATUS_OFS, 32'h40);
    @(negedge clock);
    cfg.slave_write_enable <= 1'b0;
    cfg.slave_read_enable <= 1'b0;
    pulse(18'h00C00);
    rd_chk(`STATUS_OFS, 32'h0);
    cfg.slave_write_enable <= 1'b1;
    cfg.slave_read_enable <= 1'b1;
    // A set bit with no active source must not appear.
    source_active_mask <= ~(32'h1 << 24);
    exp_v = `FLAG_MASK & ~(32'h1 << 24);
    wr(`SET_OFS, 32'hFFFFFFFF);
    rd_chk(`STATUS_OFS, exp_v);
    rd_chk(`SET_OFS, exp_v);
    wr(`STATUS_OFS, 32'h000000C0);
    rd_chk(`STATUS_OFS, exp_v & ~32'hC0);
    chk({31'h0, irq}, 32'h0);
    wr(`ENABLE_OFS, 32'hFFFFFFFF);
    rd_chk(`ENABLE_OFS, `FLAG_MASK);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, pending}, 32'h1);
    @(negedge clock);
    unit_soft_reset <= 1'b1;
    ack_clear <= 1'b1;
    repeat (2) @(negedge clock);
    unit_soft_reset <= 1'b0;
    ack_clear <= 1'b0;
    repeat (2) @(negedge clock);
    chk({30'h0, irq, pending}, 32'h0);
    rd_chk(`STATUS_OFS, 32'h0);
    rd_chk(`ENABLE_OFS, `FLAG_MASK);
    pulse(18'h08000);
    chk({31'h0, irq}, 32'h1);
    rd_chk(`STATUS_OFS, 32'h80);
    wr(`ENABLE_OFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd_chk(`STATUS_OFS, 32'h80);
    wr(`STATUS_OFS, 32'h00000080);
    rd_chk(`STATUS_OFS, 32'h0);
    // The clear is taken at the same edge at which the captured event reaches the flags.
    @(negedge clock);
    evt <= evt_in_t'(18'h08000);
    @(negedge clock);
    evt <= '0;
    req <= '{1'b1, 1'b1, `STATUS_OFS, 32'h00000080};
    @(negedge clock);
    req.sel <= 1'b0;
    repeat (2) @(negedge clock);
    rd_chk(`STATUS_OFS, 32'h80);
    // A second reset with boot loading enabled must leave the done flag clear.
    @(negedge clock);
    sys_rst <= 1'b1;
    cfg.boot_load_disabled <= 1'b0;
    repeat (2) @(negedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(negedge clock);
    rd_chk(`STATUS_OFS, `STATUS_RST);
    rd_chk(`ENABLE_OFS, `ENABLE_RST);
    chk({31'h0, irq}, 32'h0);
    stop_test();
  end
endmodule
